// *** rtl/phyirq_pkg.sv ***
// constants for the phy event flag, mask and negotiation status registers
package phyirq_pkg;
  // ****************************************
  // register indices on the management port
  // ****************************************
  localparam logic [4:0]  REG_EVENT_FLAGS     = 5'h1D;
  localparam logic [4:0]  REG_EVENT_MASK      = 5'h1E;
  localparam logic [4:0]  REG_NEG_STATUS      = 5'h1F;
  // ****************************************
  // field positions
  // ****************************************
  localparam int          FLAG_ENERGY         = 7;
  localparam int          FLAG_NEG_COMPLETE   = 6;
  localparam int          FLAG_REMOTE_FAULT   = 5;
  localparam int          FLAG_LINK_LOSS      = 4;
  localparam int          FLAG_PARTNER_ACK    = 3;
  localparam int          FLAG_PD_FAULT       = 2;
  localparam int          FLAG_PAGE_RX        = 1;
  localparam int          STAT_DONE_POS       = 12;
  localparam int          STAT_FIX_LSB        = 5;
  localparam int          STAT_SPD_LSB        = 2;
  // ****************************************
  // reset values and speed and duplex codes
  // ****************************************
  localparam logic [7:0]  MASK_RESET          = 8'h00;
  localparam logic [6:0]  STAT_FIX_RESET      = 7'h02;
  localparam logic [2:0]  SPD_10_HALF         = 3'h1;
  localparam logic [2:0]  SPD_10_FULL         = 3'h5;
  localparam logic [2:0]  SPD_100_HALF        = 3'h2;
  localparam logic [2:0]  SPD_100_FULL        = 3'h6;
  // ****************************************
  // energy timeout
  // ****************************************
  localparam int          CLK_MHZ             = 200;
  localparam int          ENERGY_TIMEOUT_MS   = 256;
  localparam longint      ENERGY_TIMEOUT_CYC  = longint'(ENERGY_TIMEOUT_MS) * 1000 * CLK_MHZ;
  // edges after reset during which the link loss flag is loaded from the line
  localparam logic [2:0]  SYNC_SETTLE_CYC     = 3'h5;
endpackage : phyirq_pkg

// *** rtl/phyirq_sync.sv ***
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module phyirq_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk_in,
  input  wire logic         reset_n_in,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stage two and stage three agree
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : phyirq_sync

// *** rtl/phyirq_regs.sv ***
// phy event flags, enable mask, negotiation status and interrupt request
// ****************************************
// Notes on behaviour
// RQ1 - flag bit 7 latches an energy event; zero otherwise.
// RQ2 - flag bit 6 latches negotiation completion.
// RQ3 - flag bit 5 latches a remote fault from the partner.
// RQ4 - flag bit 4 latches link going from up to down.
// RQ5 - flag bit 3 latches partner acknowledge during negotiation.
// RQ6 - flag bit 2 latches a parallel detection fault.
// RQ7 - flag bit 1 latches a received negotiation page.
// RQ8 - flag bits 15..8 and 0 read zero; writes ignored.
// RQ9 - mask bits 7..0 enable matching sources; reset to zero.
// RQ10 - link loss flag starts from the current line link state.
// RQ11 - status bit 12 reads one once negotiation is done.
// RQ12 - status bits 4..2 give the resolved speed and duplex code.
// RQ13 - speed code after reset follows the negotiation result.
// RQ14 - status bits 11..5 reset to 0000010b; host writes that pattern.
// RQ15 - energy present drops after 256 ms without line energy; feeds bit 7.
// RQ16 - flags stay set until the flag register is read.
// RQ17 - interrupt request high while any enabled flag is set.
// ****************************************
`timescale 1ns/1ps
module phyirq_regs #(
  parameter longint ENERGY_TIMEOUT = phyirq_pkg::ENERGY_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  // management register port
  input  wire logic        mgmt_rd_in,
  input  wire logic        mgmt_wr_in,
  input  wire logic [4:0]  mgmt_addr_in,
  input  wire logic [15:0] mgmt_wdata_in,
  output logic      [15:0] mgmt_rdata_out,
  // line and negotiation events, asynchronous to mclk
  input  wire logic        line_energy_in,
  input  wire logic        link_up_in,
  input  wire logic        neg_done_in,
  input  wire logic        remote_fault_in,
  input  wire logic        partner_ack_in,
  input  wire logic        pd_fault_in,
  input  wire logic        page_rx_in,
  input  wire logic [2:0]  resolved_speed_duplex_in,
  // outputs
  output logic             line_energy_present_out,
  output logic             irq_out
);
  localparam int CW = 34;
  localparam logic [CW-1:0] TMO = CW'(ENERGY_TIMEOUT);

  logic [7:3]    sy;
  logic [2:0]    spd_sy;
  logic          energy_s;
  logic          link_s;
  logic [7:0]    flags_q;
  logic [7:0]    ev;
  logic [7:0]    mask_q;
  logic [6:0]    fix_q;
  logic [2:0]    resolved_speed_duplex_q;
  logic          done_q;
  logic          link_prev_q;
  logic          neg_prev_q;
  logic [4:0]    pulse_prev_q;
  logic [CW-1:0] quiet_q;
  logic [2:0]    settle_q;
  logic          started_q;
  logic          rd_flags;

  phyirq_sync #(.W(10)) u_sync (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({line_energy_in, link_up_in, neg_done_in, remote_fault_in,
                  partner_ack_in, pd_fault_in, page_rx_in,
                  resolved_speed_duplex_in}),
    .sync_out   ({energy_s, link_s, sy[7:3], spd_sy})
  );

  // ****************************************
  // energy presence timer
  // ****************************************
  // energy present resets to one and falls after the quiet interval
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      quiet_q                 <= '0;
      line_energy_present_out <= 1'b1;
    end else if (energy_s) begin
      quiet_q                 <= '0;
      line_energy_present_out <= 1'b1;
    end else if (quiet_q >= TMO - CW'(1)) begin
      line_energy_present_out <= 1'b0; // [RQ15]
    end else begin
      quiet_q <= quiet_q + CW'(1);
    end
  end

  // ****************************************
  // event detection
  // ****************************************
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_prev_q  <= 1'b0;
      neg_prev_q   <= 1'b0;
      pulse_prev_q <= 5'h00;
      settle_q     <= 3'h0;
    end else begin
      link_prev_q  <= link_s;
      neg_prev_q   <= sy[7];
      pulse_prev_q <= sy[7:3];
      if (settle_q != phyirq_pkg::SYNC_SETTLE_CYC) begin
        settle_q <= settle_q + 3'h1;
      end
    end
  end

  // the synchroniser shows its reset value for the first edges, so the link
  // loss flag is loaded from the line until the real state has come through
  assign started_q = (settle_q == phyirq_pkg::SYNC_SETTLE_CYC);

  logic energy_prev_q;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      energy_prev_q <= 1'b1;
    end else begin
      energy_prev_q <= line_energy_present_out;
    end
  end

  always_comb begin
    ev                                 = 8'h00;
    ev[phyirq_pkg::FLAG_ENERGY]        = line_energy_present_out & ~energy_prev_q; // [RQ1]
    ev[phyirq_pkg::FLAG_NEG_COMPLETE]  = sy[7] & ~neg_prev_q; // [RQ2]
    ev[phyirq_pkg::FLAG_REMOTE_FAULT]  = sy[6] & ~pulse_prev_q[3]; // [RQ3]
    ev[phyirq_pkg::FLAG_LINK_LOSS]     = link_prev_q & ~link_s; // [RQ4]
    ev[phyirq_pkg::FLAG_PARTNER_ACK]   = sy[5] & ~pulse_prev_q[2]; // [RQ5]
    ev[phyirq_pkg::FLAG_PD_FAULT]      = sy[4] & ~pulse_prev_q[1]; // [RQ6]
    ev[phyirq_pkg::FLAG_PAGE_RX]       = sy[3] & ~pulse_prev_q[0]; // [RQ7]
  end

  assign rd_flags = mgmt_rd_in && (mgmt_addr_in == phyirq_pkg::REG_EVENT_FLAGS);

  // ****************************************
  // latched flags
  // ****************************************
  // a read clears, but an event in the same cycle survives the clear
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_q <= 8'h00;
    end else if (!started_q) begin
      flags_q                             <= 8'h00;
      flags_q[phyirq_pkg::FLAG_LINK_LOSS] <= ~link_s; // [RQ10]
    end else begin
      flags_q <= ((rd_flags ? 8'h00 : flags_q) | ev) & 8'hFE; // [RQ16] [RQ8]
    end
  end

  // ****************************************
  // mask and status registers
  // ****************************************
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_q <= phyirq_pkg::MASK_RESET;
      fix_q  <= phyirq_pkg::STAT_FIX_RESET; // [RQ14]
    end else if (mgmt_wr_in) begin
      if (mgmt_addr_in == phyirq_pkg::REG_EVENT_MASK) begin
        mask_q <= mgmt_wdata_in[7:0]; // [RQ9]
      end
      if (mgmt_addr_in == phyirq_pkg::REG_NEG_STATUS) begin
        fix_q <= mgmt_wdata_in[phyirq_pkg::STAT_FIX_LSB +: 7];
      end
    end
  end

  // speed code takes the synchronised negotiation result, so it follows the line from the fifth edge on
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      resolved_speed_duplex_q <= 3'h0;
      done_q                  <= 1'b0;
    end else begin
      resolved_speed_duplex_q <= spd_sy; // [RQ12] [RQ13]
      done_q                  <= sy[7]; // [RQ11]
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(flags_q & mask_q); // [RQ17]
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mgmt_rdata_out <= 16'h0000;
    end else if (mgmt_rd_in) begin
      unique case (mgmt_addr_in)
        phyirq_pkg::REG_EVENT_FLAGS: mgmt_rdata_out <= {8'h00, flags_q}; // [RQ8]
        phyirq_pkg::REG_EVENT_MASK:  mgmt_rdata_out <= {8'h00, mask_q};
        phyirq_pkg::REG_NEG_STATUS:  mgmt_rdata_out <= {3'h0, done_q, fix_q,
                                                        resolved_speed_duplex_q, 2'h0};
        default:                     mgmt_rdata_out <= 16'h0000;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  irq_follows_mask_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    ##1 (irq_out == |($past(flags_q) & $past(mask_q))))
    else $error("irq does not follow enabled flags"); // [RQ17]
  flag_clear_read_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (started_q && rd_flags && ev == 8'h00) |=> (flags_q == 8'h00))
    else $error("flags not cleared by read"); // [RQ16]
  flag_sticky_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (started_q && !rd_flags) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("flag lost without read"); // [RQ16]
  reserved_zero_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (mgmt_rd_in && mgmt_addr_in == phyirq_pkg::REG_EVENT_FLAGS)
      |=> (mgmt_rdata_out[15:8] == 8'h00 && mgmt_rdata_out[0] == 1'b0))
    else $error("reserved flag bits nonzero"); // [RQ8]
  link_loss_set_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (started_q && link_prev_q && !link_s) |=> flags_q[phyirq_pkg::FLAG_LINK_LOSS])
    else $error("link loss not latched"); // [RQ4]
  mask_write_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (mgmt_wr_in && mgmt_addr_in == phyirq_pkg::REG_EVENT_MASK)
      |=> (mask_q == $past(mgmt_wdata_in[7:0])))
    else $error("mask write lost"); // [RQ9]
  energy_set_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (started_q && $rose(line_energy_present_out)) |=> flags_q[phyirq_pkg::FLAG_ENERGY])
    else $error("energy flag not latched"); // [RQ1]
  neg_set_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (started_q && sy[7] && !neg_prev_q) |=> flags_q[phyirq_pkg::FLAG_NEG_COMPLETE])
    else $error("negotiation flag not latched"); // [RQ2]
  status_read_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (mgmt_rd_in && mgmt_addr_in == phyirq_pkg::REG_NEG_STATUS)
      |=> (mgmt_rdata_out[4:2] == $past(resolved_speed_duplex_q)
           && mgmt_rdata_out[12] == $past(done_q)))
    else $error("status read mismatch"); // [RQ11] [RQ12]
  link_loss_init_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (!started_q) |=> (flags_q[phyirq_pkg::FLAG_LINK_LOSS] == !$past(link_s)))
    else $error("link loss flag not loaded from line"); // [RQ10]
endmodule : phyirq_regs

// *** tb/phyirq_host.sv ***
// management host model: one-cycle read and write strobes on the register port
`timescale 1ns/1ps
module phyirq_host (
  // clock
  input  wire logic        mclk_in,
  // register port
  output logic             rd_out,
  output logic             wr_out,
  output logic [4:0]       addr_out,
  output logic [15:0]      wdata_out,
  input  wire logic [15:0] rdata_in
);
  initial begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 5'h00;
    wdata_out = 16'h5A5A;
  end
  // strobes rise after a falling edge and drop one cycle later, after the taking edge
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge mclk_in);
    wr_out = 1'b0;
    // released data no longer shows the written word
    wdata_out = ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(negedge mclk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge mclk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask : rd_reg
endmodule : phyirq_host

// *** tb/tb.sv ***
// self-checking bench for the phy event flag, mask and status registers
`timescale 1ns/1ps
module tb;
  logic        mclk_in;
  logic        reset_n_in;
  logic        rd;
  logic        wr;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] v;
  logic        energy;
  logic [6:1]  ev;
  logic [2:0]  spd;
  logic        present;
  logic        irq;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  phyirq_host i_host (.mclk_in(mclk_in), .rd_out(rd), .wr_out(wr), .addr_out(addr),
                      .wdata_out(wdata), .rdata_in(rdata));
  // short energy timeout keeps the run brief
  phyirq_regs #(.ENERGY_TIMEOUT(50)) i_dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .mgmt_rd_in(rd), .mgmt_wr_in(wr),
    .mgmt_addr_in(addr), .mgmt_wdata_in(wdata), .mgmt_rdata_out(rdata),
    .line_energy_in(energy), .link_up_in(ev[4]), .neg_done_in(ev[6]),
    .remote_fault_in(ev[5]), .partner_ack_in(ev[3]), .pd_fault_in(ev[2]),
    .page_rx_in(ev[1]), .resolved_speed_duplex_in(spd),
    .line_energy_present_out(present), .irq_out(irq));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : wait_cyc
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values();
    i_host.rd_reg(phyirq_pkg::REG_EVENT_MASK, v);
    chk("mask", 16'h0000, v);
    i_host.rd_reg(phyirq_pkg::REG_NEG_STATUS, v);
    chk("status", 16'h0058, v);
    i_host.rd_reg(phyirq_pkg::REG_EVENT_FLAGS, v);
    chk("flags", 16'h0010, v);
    i_host.rd_reg(phyirq_pkg::REG_EVENT_FLAGS, v);
    chk("flags", 16'h0000, v);
  endtask : t_reset_values
  task automatic t_events();
    for (int b = 1; b <= 6; b++) begin
      i_host.wr_reg(phyirq_pkg::REG_EVENT_MASK, 16'h0000);
      if (b == 4) begin
        ev[4] = 1'b1;
        wait_cyc(8);
        i_host.rd_reg(phyirq_pkg::REG_EVENT_FLAGS, v);
      end
      @(negedge mclk_in);
      ev[b] = (b != 4);
      wait_cyc(8);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      // the event ends before the read: the flag has to hold on its own
      ev[b] = 1'b0;
      i_host.wr_reg(phyirq_pkg::REG_EVENT_MASK, 16'h0001 << b);
      wait_cyc(3);
      chk("irq", 16'h0001, {15'h0000, irq});
      i_host.rd_reg(phyirq_pkg::REG_EVENT_FLAGS, v);
      chk("flags", 16'h0001 << b, v);
      wait_cyc(2);
      chk("irq cleared", 16'h0000, {15'h0000, irq});
    end
  endtask : t_events
  task automatic t_energy();
    i_host.wr_reg(phyirq_pkg::REG_EVENT_MASK, 16'h0080);
    i_host.rd_reg(phyirq_pkg::REG_EVENT_FLAGS, v);
    @(negedge mclk_in);
    energy = 1'b0;
    wait_cyc(40);
    chk("present early", 16'h0001, {15'h0000, present});
    wait_cyc(30);
    chk("present", 16'h0000, {15'h0000, present});
    chk("irq idle", 16'h0000, {15'h0000, irq});
    energy = 1'b1;
    wait_cyc(10);
    chk("present", 16'h0001, {15'h0000, present});
    chk("irq energy", 16'h0001, {15'h0000, irq});
    i_host.rd_reg(phyirq_pkg::REG_EVENT_FLAGS, v);
    chk("flags", 16'h0080, v);
  endtask : t_energy
  task automatic t_reserved();
    i_host.wr_reg(phyirq_pkg::REG_EVENT_FLAGS, 16'hFFFF);
    i_host.rd_reg(phyirq_pkg::REG_EVENT_FLAGS, v);
    chk("flags", 16'h0000, v);
    i_host.wr_reg(phyirq_pkg::REG_EVENT_MASK, 16'hFFFF);
    i_host.rd_reg(phyirq_pkg::REG_EVENT_MASK, v);
    chk("mask", 16'h00FF, v);
    i_host.wr_reg(5'h1C, 16'hFFFF);
    i_host.rd_reg(5'h1C, v);
    chk("unmapped", 16'h0000, v);
  endtask : t_reserved
  task automatic t_speed();
    logic [2:0] codes [4];
    codes = '{phyirq_pkg::SPD_10_HALF, phyirq_pkg::SPD_10_FULL,
              phyirq_pkg::SPD_100_HALF, phyirq_pkg::SPD_100_FULL};
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk_in);
      spd = codes[i];
      ev[6] = i[0];
      i_host.wr_reg(phyirq_pkg::REG_NEG_STATUS, 16'h0040);
      wait_cyc(6);
      i_host.rd_reg(phyirq_pkg::REG_NEG_STATUS, v);
      chk("status", {3'h0, i[0], 7'h02, codes[i], 2'h0}, v);
    end
  endtask : t_speed
  task automatic t_reset_link_up();
    // a second reset with the link up must leave the link loss flag clear
    @(negedge mclk_in);
    reset_n_in = 1'b0;
    ev[4] = 1'b1;
    wait_cyc(16);
    reset_n_in = 1'b1;
    wait_cyc(8);
    chk("irq after reset", 16'h0000, {15'h0000, irq});
    i_host.rd_reg(phyirq_pkg::REG_EVENT_MASK, v);
    chk("mask", 16'h0000, v);
    i_host.rd_reg(phyirq_pkg::REG_EVENT_FLAGS, v);
    chk("flags", 16'h0000, v);
  endtask : t_reset_link_up
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    reset_n_in = 1'b0;
    energy = 1'b1;
    ev = 6'h00;
    spd = phyirq_pkg::SPD_100_FULL;
    wait_cyc(16);
    reset_n_in = 1'b1;
    wait_cyc(8);
    t_reset_values();
    t_events();
    t_energy();
    t_reserved();
    t_speed();
    t_reset_link_up();
    final_report();
  end
endmodule : tb
